// [rtl/hlc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module hlc_ctrl import hlc_pkg::*; #(
   parameter int CYC_PER_MS = HLC_CYC_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire hlc_reg_req_type reg_req,
   output logic reg_rvalid,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] op_mode,
   input wire logic [6:0] open_drive_period,
   input wire logic input_trigger_pin,
   input wire logic bemf_phase,
   input wire logic zc_start,
   input wire logic cal_start,
   input wire logic otp_done,
   input wire logic otp_burned,
   output logic input_is_analog,
   output hlc_src_type drive_src,
   output logic drive_phase,
   output logic zc_busy,
   output logic zc_done,
   output logic cal_busy,
   output logic cal_done,
   output logic otp_start,
   output logic otp_busy,
   output logic otp_programmed
);

   hlc_state_type s;
   hlc_state_type n;
   hlc_src_type src_now;
   logic pwm_phase;
   logic [16:0] ol_target;

   hlc_pwm_div u_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .en(s.src == HLC_SRC_PWM),
      .pwm_pin(input_trigger_pin),
      .phase(pwm_phase)
   );

   assign src_now = hlc_pick_src(s.ctl3, op_mode); // R01 R07
   assign ol_target = 17'(open_drive_period) * HLC_OL_UNIT_CYC; // R05
   assign reg_rvalid = s.rvalid;
   assign reg_rdata = s.rdata;
   assign input_is_analog = s.ctl3[HLC_INSEL_BIT]; // R01
   assign drive_src = s.src;
   assign drive_phase = s.phase;
   assign zc_busy = s.zc_run;
   assign zc_done = s.zc_done;
   assign cal_busy = s.cal_st == HLC_CAL_RUN;
   assign cal_done = s.cal_st == HLC_CAL_END;
   assign otp_start = s.otp_start;
   assign otp_busy = s.otp_st == HLC_OTP_BUSY;
   assign otp_programmed = (s.otp_st == HLC_OTP_LOCK) || otp_burned; // R12

   always_comb begin
      n = s;
      n.rvalid = 1'b0;
      n.otp_start = 1'b0;
      n.zc_done = 1'b0;
      // Register writes
      if (reg_req.wr) begin
         if (reg_req.addr == HLC_CTL3_OFS) begin
            n.ctl3 = reg_req.wdata;
         end else if (reg_req.addr == HLC_CTL4_OFS) begin
            n.zc = reg_req.wdata[HLC_ZC_LSB +: 2]; // R08 R11
            n.cal_code = reg_req.wdata[HLC_CAL_LSB +: 2]; // R09 R11
            // A second launch is ignored once memory is spent or busy
            if (reg_req.wdata[HLC_LAUNCH_BIT] && s.otp_st == HLC_OTP_IDLE && !otp_burned) begin
               n.launch = 1'b1; // R13
               n.otp_st = HLC_OTP_BUSY;
               n.otp_start = 1'b1;
            end
         end
      end
      // Register reads, answered one cycle later
      if (reg_req.rd) begin
         n.rvalid = 1'b1;
         if (reg_req.addr == HLC_CTL3_OFS) begin
            n.rdata = s.ctl3;
         end else if (reg_req.addr == HLC_CTL4_OFS) begin
            n.rdata = {s.zc, s.cal_code, 1'b0, otp_programmed, 1'b0, s.launch}; // R11 R14
         end else begin
            n.rdata = 8'h00;
         end
      end
      // Programming sequence
      case (s.otp_st)
         HLC_OTP_IDLE: begin
            if (otp_burned) begin
               n.otp_st = HLC_OTP_LOCK;
            end
         end
         HLC_OTP_BUSY: begin
            if (otp_done) begin
               n.otp_st = HLC_OTP_LOCK; // R12
               n.launch = 1'b0;
            end
         end
         default: begin
            n.otp_st = HLC_OTP_LOCK;
         end
      endcase
      // Calibration timer, runs for the least length of the chosen span
      case (s.cal_st)
         HLC_CAL_IDLE: begin
            if (cal_start) begin
               n.cal_st = HLC_CAL_RUN;
               n.cal_run_code = s.cal_code;
               n.ms_div = 14'h0;
               n.ms_cnt = 10'h0;
            end
         end
         HLC_CAL_RUN: begin
            if (s.ms_div == 14'(CYC_PER_MS - 1)) begin
               n.ms_div = 14'h0;
               n.ms_cnt = s.ms_cnt + 10'h1;
               if (s.ms_cnt + 10'h1 == hlc_cal_ms(s.cal_run_code)) begin
                  n.cal_st = HLC_CAL_END; // R09
               end
            end else begin
               n.ms_div = s.ms_div + 14'h1;
            end
         end
         default: begin
            n.cal_st = HLC_CAL_IDLE;
         end
      endcase
      // Zero-crossing detect window
      if (s.zc_run) begin
         n.zc_cnt = s.zc_cnt + 12'h1;
         if (s.zc_cnt == hlc_zc_cycles(s.zc_run_code) - 12'h1) begin
            n.zc_run = 1'b0; // R08
            n.zc_done = 1'b1;
         end
      end else if (zc_start) begin
         n.zc_run = 1'b1;
         n.zc_run_code = s.zc;
         n.zc_cnt = 12'h0;
      end
      // Period-based open-loop drive; a zero period holds the phase
      if (s.src == HLC_SRC_PER && open_drive_period != 7'h0) begin
         if (s.ol_cnt >= ol_target - 17'h1) begin
            n.ol_cnt = 17'h0;
            n.ol_phase = !s.ol_phase; // R05
         end else begin
            n.ol_cnt = s.ol_cnt + 17'h1;
         end
      end else begin
         n.ol_cnt = 17'h0;
      end
      // Analog input never runs open loop, it falls back to tracking
      n.src = src_now; // R02 R06
      case (s.src)
         HLC_SRC_PWM: n.phase = pwm_phase; // R03
         HLC_SRC_PER: n.phase = s.ol_phase; // R02
         default: n.phase = bemf_phase; // R07
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= HLC_ST_RST;
      end else begin
         s <= n;
      end
   end

   // Helper counters for timed checks
   logic [11:0] zc_age;
   logic [31:0] cal_age;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         zc_age <= 12'h0;
         cal_age <= 32'h0;
      end else begin
         zc_age <= s.zc_run ? zc_age + 12'h1 : 12'h0;
         cal_age <= cal_busy ? cal_age + 32'h1 : 32'h0;
      end
   end

   src_pwm_a: assert property (@(posedge clk_sys) disable iff (rst) // R01
      s.ctl3[HLC_LOOP_BIT] && !s.ctl3[HLC_INSEL_BIT] && op_mode == HLC_MODE_PWM_ANALOG
      |=> drive_src == HLC_SRC_PWM)
      else $error("PWM open loop not selected");
   open_ignores_res_a: assert property (@(posedge clk_sys) disable iff (rst) // R02
      drive_src == HLC_SRC_PER ##1 drive_src == HLC_SRC_PER |-> drive_phase == $past(s.ol_phase))
      else $error("open loop followed resonance");
   pwm_phase_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
      drive_src == HLC_SRC_PWM |=> drive_phase == $past(pwm_phase))
      else $error("drive phase not from divider");
   src_period_a: assert property (@(posedge clk_sys) disable iff (rst) // R05
      s.ctl3[HLC_LOOP_BIT] && !s.ctl3[HLC_INSEL_BIT] && op_mode != HLC_MODE_PWM_ANALOG
      |=> drive_src == HLC_SRC_PER)
      else $error("period source not selected");
   loop_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R07
      !s.ctl3[HLC_LOOP_BIT] |=> drive_src == HLC_SRC_RES ##1 drive_phase == $past(bemf_phase))
      else $error("loop bit 0 not auto-resonance");
   zc_window_a: assert property (@(posedge clk_sys) disable iff (rst) // R08
      zc_done |-> $past(zc_age) == hlc_zc_cycles(s.zc_run_code) - 12'h1)
      else $error("crossing window length wrong");
   cal_length_a: assert property (@(posedge clk_sys) disable iff (rst) // R09
      $fell(cal_busy)
      |-> $past(cal_age) + 32'h1 == 32'(hlc_cal_ms(s.cal_run_code)) * 32'(CYC_PER_MS))
      else $error("calibration length wrong");
   ctl4_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R11 R14
      reg_req.rd && reg_req.addr == HLC_CTL4_OFS
      |=> reg_rvalid && reg_rdata[3] == 1'b0 && reg_rdata[1] == 1'b0
         && reg_rdata[7:6] == $past(s.zc))
      else $error("fourth control read wrong");
   otp_status_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
      otp_busy && otp_done |=> otp_programmed [*2])
      else $error("status not set after programming");
   otp_once_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
      reg_req.wr && reg_req.addr == HLC_CTL4_OFS && reg_req.wdata[HLC_LAUNCH_BIT]
      |=> otp_start == ($past(s.otp_st) == HLC_OTP_IDLE && !$past(otp_burned)))
      else $error("launch not once only");

   cal_done_c: cover property (@(posedge clk_sys) disable iff (rst) cal_done);
   otp_run_c: cover property (@(posedge clk_sys) disable iff (rst) otp_start ##[1:20] otp_programmed);
   zc_done_c: cover property (@(posedge clk_sys) disable iff (rst) zc_done);
   per_toggle_c: cover property (@(posedge clk_sys) disable iff (rst)
      drive_src == HLC_SRC_PER && $changed(drive_phase));

endmodule
`default_nettype wire

// [pkg/hlc_pkg.sv]
// Functional notes
// R01: With mode 3, the input-select bit picks PWM duty (0) or analog level (1) for amplitude.
// R02: With the loop-select bit set, drive runs at the chosen frequency, ignoring resonance.
// R03: Open loop with PWM input takes the commutation frequency as PWM frequency over 128.
// R04: For open loop from PWM the host supplies exactly 128 times the actuator resonance.
// R05: Open loop in real-time or memory playback takes its rate from the 7-bit period field.
// R06: The host never combines open-loop drive with analog input interpretation.
// R07: The loop-select bit means 0 auto-resonance and 1 open loop, and resets to 0.
// R08: The crossing field sets the least detect window 100, 200, 300 or 390 us; resets to 0.
// R09: Calibration code 0 lasts 150 to 350 ms and code 1 lasts 250 to 450 ms.
// R10: The host picks a calibration long enough to settle at the nominal drive level.
// R11: Fourth control: crossing window 7-6, calibration 5-4, memory status 2, launch 0.
// R12: The memory status bit is read-only: 0 while unprogrammed, 1 once programmed.
// R13: Writing 1 to launch programs registers 0x16 to 0x1A into memory, once per device.
// R14: Reserved bits 3 and 1 of the fourth control register read zero and ignore writes.
package hlc_pkg;

   localparam int HLC_CLK_NS = 100;
   localparam int HLC_US_NS = 1000;
   localparam int HLC_MS_NS = 1000000;
   localparam int HLC_CYC_PER_MS = HLC_MS_NS / HLC_CLK_NS;

   localparam logic [7:0] HLC_CTL3_OFS = 8'h1D;
   localparam logic [7:0] HLC_CTL4_OFS = 8'h1E;
   localparam logic [7:0] HLC_OTP_FIRST_OFS = 8'h16;
   localparam logic [7:0] HLC_OTP_LAST_OFS = 8'h1A;
   localparam logic [7:0] HLC_CTL3_RST = 8'h80;
   localparam logic [1:0] HLC_ZC_RST = 2'h0;
   localparam logic [1:0] HLC_CAL_RST = 2'h2;

   localparam int HLC_LOOP_BIT = 0;
   localparam int HLC_INSEL_BIT = 1;
   localparam int HLC_ZC_LSB = 6;
   localparam int HLC_CAL_LSB = 4;
   localparam int HLC_STATUS_BIT = 2;
   localparam int HLC_LAUNCH_BIT = 0;

   localparam logic [2:0] HLC_MODE_PWM_ANALOG = 3'h3;
   localparam int HLC_PWM_DIV = 128;
   localparam logic [5:0] HLC_PWM_HALF_LAST = 6'(HLC_PWM_DIV / 2 - 1);

   // Open-loop period unit: one period step, in microseconds
   localparam int HLC_OL_UNIT_US = 100;
   localparam logic [16:0] HLC_OL_UNIT_CYC = 17'(HLC_OL_UNIT_US * HLC_US_NS / HLC_CLK_NS);

   localparam int HLC_ZC_US [4] = '{100, 200, 300, 390};
   localparam int HLC_CAL_MIN_MS [4] = '{150, 250, 500, 1000};

   typedef enum logic [1:0] {
      HLC_SRC_RES = 2'h0,
      HLC_SRC_PWM = 2'h1,
      HLC_SRC_PER = 2'h3
   } hlc_src_type;

   typedef enum logic [1:0] {
      HLC_CAL_IDLE = 2'h0,
      HLC_CAL_RUN = 2'h1,
      HLC_CAL_END = 2'h3
   } hlc_cal_type;

   typedef enum logic [1:0] {
      HLC_OTP_IDLE = 2'h0,
      HLC_OTP_BUSY = 2'h1,
      HLC_OTP_LOCK = 2'h3
   } hlc_otp_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hlc_reg_req_type;

   typedef struct packed {
      logic [7:0] ctl3;
      logic [1:0] zc;
      logic [1:0] cal_code;
      logic launch;
      hlc_otp_type otp_st;
      hlc_cal_type cal_st;
      logic [1:0] cal_run_code;
      logic [13:0] ms_div;
      logic [9:0] ms_cnt;
      logic zc_run;
      logic [1:0] zc_run_code;
      logic [11:0] zc_cnt;
      logic zc_done;
      logic [16:0] ol_cnt;
      logic ol_phase;
      hlc_src_type src;
      logic phase;
      logic otp_start;
      logic rvalid;
      logic [7:0] rdata;
   } hlc_state_type;

   localparam hlc_state_type HLC_ST_RST = '{
      ctl3: HLC_CTL3_RST, zc: HLC_ZC_RST, cal_code: HLC_CAL_RST, launch: 1'b0,
      otp_st: HLC_OTP_IDLE, cal_st: HLC_CAL_IDLE, cal_run_code: 2'h0, ms_div: 14'h0,
      ms_cnt: 10'h0, zc_run: 1'b0, zc_run_code: 2'h0, zc_cnt: 12'h0, zc_done: 1'b0,
      ol_cnt: 17'h0, ol_phase: 1'b0, src: HLC_SRC_RES, phase: 1'b0, otp_start: 1'b0,
      rvalid: 1'b0, rdata: 8'h0};

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic [5:0] cnt;
      logic phase;
   } hlc_div_state_type;

   localparam hlc_div_state_type HLC_DIV_RST = '{
      s1: 1'b0, s2: 1'b0, s3: 1'b0, lvl: 1'b0, cnt: 6'h0, phase: 1'b0};

   // Least window rounds up to whole cycles
   function automatic logic [11:0] hlc_zc_cycles(input logic [1:0] code);
      hlc_zc_cycles = 12'((HLC_ZC_US[code] * HLC_US_NS + HLC_CLK_NS - 1) / HLC_CLK_NS);
   endfunction

   function automatic logic [9:0] hlc_cal_ms(input logic [1:0] code);
      hlc_cal_ms = 10'(HLC_CAL_MIN_MS[code]);
   endfunction

   function automatic hlc_src_type hlc_pick_src(input logic [7:0] ctl3, input logic [2:0] mode);
      if (!ctl3[HLC_LOOP_BIT] || ctl3[HLC_INSEL_BIT]) begin
         hlc_pick_src = HLC_SRC_RES;
      end else if (mode == HLC_MODE_PWM_ANALOG) begin
         hlc_pick_src = HLC_SRC_PWM;
      end else begin
         hlc_pick_src = HLC_SRC_PER;
      end
   endfunction

endpackage

// [rtl/hlc_pwm_div.sv]
`timescale 1ns/10ps
`default_nettype none
module hlc_pwm_div import hlc_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic en,
   input wire logic pwm_pin,
   output logic phase
);

   hlc_div_state_type s;
   hlc_div_state_type n;
   logic rise;

   // Edge counted only once the second and third stages agree
   assign rise = (s.s2 == s.s3) && s.s3 && !s.lvl;
   assign phase = s.phase;

   always_comb begin
      n = s;
      n.s1 = pwm_pin;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3) begin
         n.lvl = s.s3;
      end
      if (!en) begin
         n.cnt = 6'h0;
         n.phase = 1'b0;
      end else if (rise) begin
         n.cnt = s.cnt + 6'h1; // R03
         if (s.cnt == HLC_PWM_HALF_LAST) begin
            n.phase = !s.phase; // R03
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= HLC_DIV_RST;
      end else begin
         s <= n;
      end
   end

   div_toggle_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
      en && rise && s.cnt == HLC_PWM_HALF_LAST |=> phase != $past(phase))
      else $error("phase did not toggle on 64th edge");
   div_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
      en && !(rise && s.cnt == HLC_PWM_HALF_LAST) |=> phase == $past(phase) || !$past(en))
      else $error("phase changed between edges");
   div_toggle_c: cover property (@(posedge clk_sys) disable iff (rst) en && $changed(phase));

endmodule
`default_nettype wire

// [sim/hlc_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hlc_far_model import hlc_pkg::*; #(
   parameter int PWM_HALF = 4,
   parameter int OTP_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic otp_start,
   output logic pwm_pin,
   output logic otp_done,
   output logic otp_burned
);
   int pwm_cnt;
   int otp_cnt;
   // Free-running PWM, standing for 128 times the actuator resonance
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwm_cnt <= 0;
         pwm_pin <= 1'b0;
      end else if (pwm_cnt == PWM_HALF - 1) begin
         pwm_cnt <= 0;
         pwm_pin <= ~pwm_pin;
      end else begin
         pwm_cnt <= pwm_cnt + 1;
      end
   end
   // Memory macro: burning takes a while, then stays burned for good
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         otp_cnt <= 0;
         otp_done <= 1'b0;
         otp_burned <= 1'b0;
      end else begin
         otp_done <= (otp_cnt == 1);
         if (otp_cnt == 1) begin
            otp_burned <= 1'b1;
         end
         if (otp_start === 1'b1) begin
            otp_cnt <= OTP_CYC;
         end else if (otp_cnt > 0) begin
            otp_cnt <= otp_cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// [sim/test_haptic_lra_loop_and_calibration_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module test_haptic_lra_loop_and_calibration_ctrl import hlc_pkg::*;;
   localparam int PWM_HALF = 4;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   hlc_reg_req_type req = '0;
   logic [2:0] op_mode = 3'h0;
   logic [6:0] odp = 7'h0;
   logic zc_start = 1'b0;
   logic cal_start = 1'b0;
   logic rvalid, pwm_pin, otp_done, otp_burned, analog, dphase, zc_busy, zc_done;
   logic cal_busy, cal_done, otp_start, otp_busy, otp_prog;
   logic [7:0] rdata;
   hlc_src_type dsrc;
   int errors = 0;
   int checks_done = 0;
   int starts = 0;
   int n;
   logic dn;
   logic bemf = 1'b0;
   int zc_exp [4] = '{1000, 2000, 3000, 3900};
   int cal_exp [4] = '{150, 250, 500, 1000};

   always #50 clk_sys = ~clk_sys;
   // Tracker phase toggles every cycle, so a stuck follow path cannot hide
   always @(posedge clk_sys) bemf <= ~bemf;
   always @(negedge clk_sys) starts += (otp_start === 1'b1);

   hlc_ctrl #(.CYC_PER_MS(10)) hlc_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .reg_req(req),
      .reg_rvalid(rvalid), .reg_rdata(rdata), .op_mode(op_mode), .open_drive_period(odp),
      .input_trigger_pin(pwm_pin), .bemf_phase(bemf), .zc_start(zc_start),
      .cal_start(cal_start), .otp_done(otp_done), .otp_burned(otp_burned),
      .input_is_analog(analog), .drive_src(dsrc), .drive_phase(dphase), .zc_busy(zc_busy),
      .zc_done(zc_done), .cal_busy(cal_busy), .cal_done(cal_done), .otp_start(otp_start),
      .otp_busy(otp_busy), .otp_programmed(otp_prog));
   hlc_far_model #(.PWM_HALF(PWM_HALF), .OTP_CYC(20)) hlc_far_model_inst (.clk_sys(clk_sys),
      .rst(rst), .otp_start(otp_start), .pwm_pin(pwm_pin), .otp_done(otp_done),
      .otp_burned(otp_burned));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      if (errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      req <= '0;
      @(posedge clk_sys);
   endtask
   // Read data is taken only with its valid pulse, so a stale byte cannot pass
   task rdc(input logic [7:0] a, input logic [7:0] exp);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      req <= '0;
      @(negedge clk_sys);
      for (int i = 0; i < 3 && rvalid !== 1'b1; i++) @(negedge clk_sys);
      chk({7'h00, rvalid, rdata}, {8'h01, exp});
      @(posedge clk_sys);
   endtask
   task busy_len(input logic sel, output int cnt, output logic fin);
      cnt = 0;
      fin = 1'b0;
      for (int i = 0; i < 20000; i++) begin
         @(negedge clk_sys);
         if ((sel ? cal_busy : zc_busy) === 1'b1) begin
            cnt++;
         end else if (cnt > 0) begin
            fin = sel ? cal_done : zc_done;
            break;
         end
      end
      @(posedge clk_sys);
   endtask
   // The first toggle after a source change may be partial; the second is timed
   task tog_len(output int cnt);
      logic last;
      cnt = 0;
      @(negedge clk_sys);
      last = dphase;
      for (int i = 0; i < 5000 && dphase === last; i++) @(negedge clk_sys);
      last = dphase;
      for (int i = 0; i < 5000 && dphase === last; i++) begin
         @(negedge clk_sys);
         cnt++;
      end
      @(posedge clk_sys);
   endtask
   task src_chk(input logic [7:0] c3, input hlc_src_type exp);
      wr(HLC_CTL3_OFS, c3);
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk({14'h0, dsrc}, {14'h0, exp});
      chk({15'h0, analog}, {15'h0, c3[1]});
      if (exp == HLC_SRC_RES) begin
         chk({15'h0, dphase}, {15'h0, ~bemf});
      end
      @(posedge clk_sys);
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys);
      errors++;
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk({14'h0, dsrc}, 16'h0000);
      @(posedge clk_sys);
      rdc(HLC_CTL3_OFS, 8'h80);
      rdc(HLC_CTL4_OFS, 8'h20);
      rdc(8'h10, 8'h00);
      wr(HLC_CTL4_OFS, 8'h0A);
      rdc(HLC_CTL4_OFS, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(HLC_CTL4_OFS, {2'(c), 2'(c), 4'h0});
         rdc(HLC_CTL4_OFS, {2'(c), 2'(c), 4'h0});
         zc_start <= 1'b1;
         @(posedge clk_sys);
         zc_start <= 1'b0;
         busy_len(1'b0, n, dn);
         chk(16'(n), 16'(zc_exp[c]));
         chk({15'h0, dn}, 16'h0001);
         cal_start <= 1'b1;
         @(posedge clk_sys);
         cal_start <= 1'b0;
         busy_len(1'b1, n, dn);
         chk(16'(n), 16'(cal_exp[c] * 10));
         chk({15'h0, dn}, 16'h0001);
      end
      op_mode <= HLC_MODE_PWM_ANALOG;
      src_chk(8'h81, HLC_SRC_PWM);
      tog_len(n);
      chk(16'(n), 16'(HLC_PWM_DIV * PWM_HALF));
      src_chk(8'h83, HLC_SRC_RES);
      op_mode <= 3'h5;
      odp <= 7'h02;
      src_chk(8'h81, HLC_SRC_PER);
      tog_len(n);
      chk(16'(n), 16'(2 * HLC_OL_UNIT_CYC));
      src_chk(8'h80, HLC_SRC_RES);
      wr(HLC_CTL4_OFS, 8'hFF);
      rdc(HLC_CTL4_OFS, 8'hF1);
      chk({15'h0, otp_busy}, 16'h0001);
      chk(16'(starts), 16'h0001);
      repeat (40) @(posedge clk_sys);
      chk({15'h0, otp_busy}, 16'h0000);
      rdc(HLC_CTL4_OFS, 8'hF4);
      chk({15'h0, otp_prog}, 16'h0001);
      wr(HLC_CTL4_OFS, 8'h3F);
      repeat (5) @(posedge clk_sys);
      chk(16'(starts), 16'h0001);
      rdc(HLC_CTL4_OFS, 8'h34);
      end_of_test();
   end
endmodule
`default_nettype wire
